// *** src/cpu_interrupt_acceptance_pkg.sv ***
// Constants for the CPU interrupt acceptance and exception-return block.
// Assumes a 32-bit PC and a single CPU clock domain.
package cpu_interrupt_acceptance_pkg;

	// ==========================================================
	// Status word field positions
	// ==========================================================
	localparam int STATUS_PRIV_POS  = 30;
	localparam int STATUS_BANK_POS  = 29;
	localparam int STATUS_BLOCK_POS = 28;
	localparam int STATUS_MASK_LSB  = 4;
	localparam int MASK_W           = 4;
	localparam int CODE_W           = 12;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [31:0] STATUS_RESET      = 32'h700000f0;
	localparam logic [31:0] VECTOR_BASE_RESET = 32'h00000000;
	localparam logic [31:0] RESET_VECTOR      = 32'ha0000000;

	// ==========================================================
	// Vector offsets and event codes
	// ==========================================================
	localparam logic [31:0] GENERAL_EXC_OFFSET = 32'h00000100;
	localparam logic [31:0] INTERRUPT_OFFSET   = 32'h00000600;
	localparam logic [CODE_W-1:0] NMI_CODE     = 12'h1c0;
	localparam logic [CODE_W-1:0] LEVEL_BASE   = 12'h200;
	localparam logic [CODE_W-1:0] LEVEL_STEP   = 12'h020;
	localparam logic [CODE_W-1:0] DEBUG_CODE   = 12'h5e0;
	localparam logic [MASK_W-1:0] DEBUG_LEVEL  = 4'hf;

	// ==========================================================
	// CPU state pin codes
	// ==========================================================
	localparam logic [1:0] CPU_STATE_NORMAL = 2'h0;
	localparam logic [1:0] CPU_STATE_RESET  = 2'h3;

	// ==========================================================
	// APB register byte offsets
	// ==========================================================
	localparam logic [7:0] ADDR_STATUS_WORD  = 8'h00;
	localparam logic [7:0] ADDR_SAVED_PC     = 8'h04;
	localparam logic [7:0] ADDR_SAVED_STATUS = 8'h08;
	localparam logic [7:0] ADDR_VECTOR_BASE  = 8'h0c;
	localparam logic [7:0] ADDR_INT_CODE     = 8'h10;
	localparam logic [7:0] ADDR_INT_CODE_2   = 8'h14;
	localparam logic [7:0] ADDR_EXC_CODE     = 8'h18;
	localparam logic [7:0] ADDR_PC           = 8'h1c;

	// Source taken in a cycle
	typedef enum logic [2:0] {
		SRC_NONE, SRC_NMI, SRC_LEVEL, SRC_CTRL, SRC_DEBUG
	} source_e;

endpackage : cpu_interrupt_acceptance_pkg

// *** src/cpu_interrupt_acceptance.sv ***
// CPU-side interrupt acceptance, exception entry and exception return.
// Assumes the pipeline marks instruction boundaries and supplies the PCs
// needed for the saved PC; the interrupt controller presents one request.
//
// Functional notes
// - NMI edge saves PC, status, code 1c0
// - NMI ignores mask, top priority, blocked
// - Level inputs taken when above mask, unblocked
// - Level code is 200 plus level times 20
// - Accepted level never written into mask
// - Direct pin request above mask, unblocked
// - Port pin request above mask, unblocked
// - Peripheral request above mask, unblocked
// - Debug command taken when mask below 15
// - Acceptance sets block, privilege, bank; vector 600
// - Return restores PC and status, branches
// - Block defers requests until block clears
// - Sleep or standby accepts despite block
// - No user break trap while blocked
// - Blocked exception branches to reset vector
// - Blocked reset: reset pin idle, state pins reset
// - Re-executing exceptions save faulting or branch PC
// - Completed types save next or target PC
// - Reset values of base, status and PC
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps

module cpu_interrupt_acceptance
	import cpu_interrupt_acceptance_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                 i_clock,
	input  wire logic                 i_rst,
	input  wire logic                 i_enable,
	// APB slave
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [7:0]           i_paddr,
	input  wire logic [31:0]          i_pwdata,
	output logic      [31:0]          o_prdata,
	output logic                      o_pready,
	output logic                      o_pslverr,
	// Pipeline
	input  wire logic                 i_boundary,
	input  wire logic                 i_sleep,
	input  wire logic [31:0]          i_cur_pc,
	input  wire logic [31:0]          i_next_pc,
	input  wire logic                 i_in_delay_slot,
	input  wire logic                 i_cond_branch,
	input  wire logic                 i_cond_failed,
	input  wire logic [31:0]          i_branch_pc,
	input  wire logic [31:0]          i_branch_target,
	input  wire logic [31:0]          i_delay_slot_pc,
	input  wire logic                 i_return_from_exception,
	// Exceptions
	input  wire logic                 i_exc_req,
	input  wire logic                 i_exc_reexec,
	input  wire logic                 i_exc_user_break,
	input  wire logic [CODE_W-1:0]    i_exc_code,
	// Interrupt sources
	input  wire logic                 i_nmi,
	input  wire logic [MASK_W-1:0]    i_encoded_level_inputs,
	input  wire logic                 i_ctrl_req,
	input  wire logic [MASK_W-1:0]    i_ctrl_level,
	input  wire logic [CODE_W-1:0]    i_ctrl_code,
	input  wire logic                 i_debug_port_cmd,
	// Control flow and state out
	output logic                      o_branch,
	output logic      [31:0]          o_branch_addr,
	output logic                      o_ctrl_accept,
	output logic      [31:0]          o_status_word,
	output logic                      o_reset_output_pin,
	output logic                      o_cpu_state_pin_low,
	output logic                      o_cpu_state_pin_high
);

	// ==========================================================
	// State
	// ==========================================================
	logic [31:0]       status_word;
	logic [31:0]       saved_pc;
	logic [31:0]       saved_status;
	logic [31:0]       vector_base;
	logic [31:0]       pc;
	logic [CODE_W-1:0] interrupt_event_code;
	logic [CODE_W-1:0] interrupt_event_code_second;
	logic [CODE_W-1:0] exception_event_code;
	logic              nmi_prev;
	logic              nmi_pending;
	logic              debug_pending;
	logic [1:0]        cpu_state;

	// ==========================================================
	// Decode of the current status word
	// ==========================================================
	logic              block_bit;
	logic [MASK_W-1:0] mask_level;
	logic              may_accept;
	logic [CODE_W-1:0] level_code;
	logic              nmi_edge;
	logic              apb_write;
	logic              apb_setup;

	assign block_bit  = status_word[STATUS_BLOCK_POS];
	assign mask_level = status_word[STATUS_MASK_LSB +: MASK_W];
	// Sleep keeps the door open even with the block bit set
	assign may_accept = i_boundary && (!block_bit || i_sleep);
	assign level_code = LEVEL_BASE
		+ CODE_W'(i_encoded_level_inputs) * LEVEL_STEP;
	assign nmi_edge   = i_nmi && !nmi_prev;
	assign apb_write  = i_psel && i_penable && o_pready && i_pwrite;
	assign apb_setup  = i_psel && !i_penable;

	// ==========================================================
	// Source selection, fixed priority
	// ==========================================================
	source_e           take;
	logic [CODE_W-1:0] take_code;
	logic              exc_blocked;
	logic              exc_take;
	logic [31:0]       exc_saved_pc;
	logic [31:0]       int_saved_pc;

	// Exceptions and return precede interrupts at the same boundary
	always_comb
	begin
		take      = SRC_NONE;
		take_code = NMI_CODE;
		if (!may_accept || i_exc_req || i_return_from_exception)
			take = SRC_NONE;
		else if (nmi_pending || nmi_edge)
			take = SRC_NMI;
		else if (mask_level < i_encoded_level_inputs)
		begin
			take      = SRC_LEVEL;
			take_code = level_code;
		end
		else if (i_ctrl_req && mask_level < i_ctrl_level)
		begin
			take      = SRC_CTRL;
			take_code = i_ctrl_code;
		end
		else if (debug_pending && mask_level < DEBUG_LEVEL)
		begin
			take      = SRC_DEBUG;
			take_code = DEBUG_CODE;
		end
	end

	// Blocked user break is dropped; other blocked exceptions reset
	assign exc_blocked = i_boundary && i_exc_req && block_bit && !i_exc_user_break;
	assign exc_take    = i_boundary && i_exc_req && !block_bit;

	// Saved PC for exceptions by type and delay-slot position
	always_comb
	begin
		if (i_exc_reexec)
		begin
			if (i_in_delay_slot)
				exc_saved_pc = i_cond_failed ? i_delay_slot_pc : i_branch_pc;
			else
				exc_saved_pc = i_cur_pc;
		end
		else if (i_cond_branch)
			exc_saved_pc = i_cond_failed ? i_delay_slot_pc : i_branch_target;
		else
			exc_saved_pc = i_next_pc;
	end

	// Interrupts are completed-type: resume after the boundary
	always_comb
	begin
		if (i_cond_branch)
			int_saved_pc = i_cond_failed ? i_delay_slot_pc : i_branch_target;
		else
			int_saved_pc = i_next_pc;
	end

	// ==========================================================
	// Status word: hardware events win over a software write
	// ==========================================================
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			status_word <= STATUS_RESET;
		else if (i_enable)
		begin
			if (exc_take || take != SRC_NONE)
			begin
				// Mask field left alone on purpose
				status_word[STATUS_BLOCK_POS] <= 1'b1;
				status_word[STATUS_PRIV_POS]  <= 1'b1;
				status_word[STATUS_BANK_POS]  <= 1'b1;
			end
			else if (i_boundary && i_return_from_exception && !exc_blocked)
				status_word <= saved_status;
			else if (apb_write && i_paddr == ADDR_STATUS_WORD)
				status_word <= i_pwdata;
		end
	end

	// ==========================================================
	// Saved PC, saved status and event codes
	// ==========================================================
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			saved_pc                    <= 32'h00000000;
			saved_status                <= 32'h00000000;
			interrupt_event_code        <= 12'h000;
			interrupt_event_code_second <= 12'h000;
			exception_event_code        <= 12'h000;
		end
		else if (i_enable)
		begin
			// Blocked exceptions leave these untouched (contents undefined)
			if (exc_take)
			begin
				saved_pc             <= exc_saved_pc;
				saved_status         <= status_word;
				exception_event_code <= i_exc_code;
			end
			else if (take != SRC_NONE)
			begin
				saved_pc                    <= int_saved_pc;
				saved_status                <= status_word;
				interrupt_event_code        <= take_code;
				interrupt_event_code_second <= take_code;
			end
			else if (apb_write)
			begin
				// Handlers reload spilled copies here with block set first
				if (i_paddr == ADDR_SAVED_PC)
					saved_pc <= i_pwdata;
				if (i_paddr == ADDR_SAVED_STATUS)
					saved_status <= i_pwdata;
			end
		end
	end

	// ==========================================================
	// Vector base
	// ==========================================================
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			vector_base <= VECTOR_BASE_RESET;
		else if (i_enable && apb_write && i_paddr == ADDR_VECTOR_BASE)
			vector_base <= i_pwdata;
	end

	// ==========================================================
	// Program counter and branch request
	// ==========================================================
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			pc            <= RESET_VECTOR;
			o_branch      <= 1'b1;
			o_branch_addr <= RESET_VECTOR;
		end
		else if (i_enable)
		begin
			o_branch <= 1'b0;
			if (exc_blocked)
			begin
				pc            <= RESET_VECTOR;
				o_branch      <= 1'b1;
				o_branch_addr <= RESET_VECTOR;
			end
			else if (exc_take)
			begin
				pc            <= vector_base + GENERAL_EXC_OFFSET;
				o_branch      <= 1'b1;
				o_branch_addr <= vector_base + GENERAL_EXC_OFFSET;
			end
			else if (i_boundary && i_return_from_exception)
			begin
				pc            <= saved_pc;
				o_branch      <= 1'b1;
				o_branch_addr <= saved_pc;
			end
			else if (take != SRC_NONE)
			begin
				pc            <= vector_base + INTERRUPT_OFFSET;
				o_branch      <= 1'b1;
				o_branch_addr <= vector_base + INTERRUPT_OFFSET;
			end
			else if (i_boundary)
				pc <= i_next_pc;
		end
	end

	// ==========================================================
	// Pending edge and command flags; a new event beats the clear
	// ==========================================================
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			nmi_prev      <= 1'b0;
			nmi_pending   <= 1'b0;
			debug_pending <= 1'b0;
		end
		else if (i_enable)
		begin
			nmi_prev <= i_nmi;
			// Edge captured while blocked is held off, not lost
			if (nmi_edge && !(take == SRC_NMI && !nmi_pending))
				nmi_pending <= 1'b1;
			else if (take == SRC_NMI)
				nmi_pending <= 1'b0;
			if (i_debug_port_cmd)
				debug_pending <= 1'b1;
			else if (take == SRC_DEBUG)
				debug_pending <= 1'b0;
		end
	end

	// ==========================================================
	// Controller acknowledge and CPU state pins
	// ==========================================================
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ctrl_accept <= 1'b0;
			cpu_state     <= CPU_STATE_RESET;
		end
		else if (i_enable)
		begin
			o_ctrl_accept <= (take == SRC_CTRL);
			// Reset code shown until the next instruction boundary
			if (exc_blocked)
				cpu_state <= CPU_STATE_RESET;
			else if (i_boundary)
				cpu_state <= CPU_STATE_NORMAL;
		end
	end

	// Reset output pin never asserted by this block
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			o_reset_output_pin <= 1'b0;
		else
			o_reset_output_pin <= 1'b0;
	end

	assign o_cpu_state_pin_low  = cpu_state[0];
	assign o_cpu_state_pin_high = cpu_state[1];
	assign o_status_word        = status_word;

	// ==========================================================
	// APB slave: no wait states; read data comes from a flop loaded in the setup cycle
	// ==========================================================
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
		end
		else if (i_enable)
		begin
			o_pready  <= apb_setup;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
			if (apb_setup)
			begin
				unique case (i_paddr)
					ADDR_STATUS_WORD:  o_prdata <= status_word;
					ADDR_SAVED_PC:     o_prdata <= saved_pc;
					ADDR_SAVED_STATUS: o_prdata <= saved_status;
					ADDR_VECTOR_BASE:  o_prdata <= vector_base;
					ADDR_INT_CODE:     o_prdata <= 32'(interrupt_event_code);
					ADDR_INT_CODE_2:   o_prdata <= 32'(interrupt_event_code_second);
					ADDR_EXC_CODE:     o_prdata <= 32'(exception_event_code);
					ADDR_PC:           o_prdata <= pc;
					default:           o_pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule : cpu_interrupt_acceptance

// *** verification/cpu_interrupt_acceptance_props.sv ***
// Concurrent checks on the interrupt acceptance block's ports.
// Assumes one clock domain and a bench that never overlaps APB with boundaries.
`timescale 1ns/100ps

module cpu_interrupt_acceptance_props
	import cpu_interrupt_acceptance_pkg::*;
(
	// Clock, reset, enable
	input wire logic              i_clock,
	input wire logic              i_rst,
	input wire logic              i_enable,
	input wire logic              i_psel,
	// Pipeline and sources
	input wire logic              i_boundary,
	input wire logic              i_sleep,
	input wire logic              i_return_from_exception,
	input wire logic              i_exc_req,
	input wire logic              i_exc_user_break,
	input wire logic              i_nmi,
	input wire logic [MASK_W-1:0] i_encoded_level_inputs,
	input wire logic              i_ctrl_req,
	input wire logic [MASK_W-1:0] i_ctrl_level,
	// Outputs
	input wire logic              o_branch,
	input wire logic [31:0]       o_branch_addr,
	input wire logic              o_ctrl_accept,
	input wire logic [31:0]       o_status_word,
	input wire logic              o_reset_output_pin,
	input wire logic              o_cpu_state_pin_low,
	input wire logic              o_cpu_state_pin_high
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// ==========================================================
	// Helpers
	// ==========================================================
	// Boundary with no competing bus write or freeze
	wire logic              bnd   = i_boundary && i_enable && !i_psel;
	wire logic              blk   = o_status_word[STATUS_BLOCK_POS];
	wire logic [MASK_W-1:0] mask  = o_status_word[STATUS_MASK_LSB +: MASK_W];
	wire logic              quiet = !i_exc_req && !i_return_from_exception && !i_nmi;

	// ==========================================================
	// Assertions
	// ==========================================================
	chk_level_take: assert property (bnd && quiet && !blk && i_encoded_level_inputs > mask |=>
		o_branch && o_status_word[30:28] == 3'h7 && mask == $past(mask))
		else $error("level request above mask not taken");
	chk_block_hold: assert property (bnd && !i_exc_req && !i_return_from_exception && blk
		&& !i_sleep |=> !o_branch)
		else $error("request taken while blocked");
	chk_sleep_take: assert property (bnd && quiet && blk && i_sleep
		&& i_encoded_level_inputs > mask |=> o_branch)
		else $error("sleep request not taken");
	chk_break_drop: assert property (bnd && i_exc_req && i_exc_user_break && blk && !i_sleep
		&& !i_return_from_exception |=> !o_branch && $stable(o_status_word))
		else $error("user break acted while blocked");
	chk_blocked_exc: assert property (bnd && i_exc_req && !i_exc_user_break && blk && !i_sleep
		|=> o_branch && o_branch_addr == RESET_VECTOR && o_cpu_state_pin_low && o_cpu_state_pin_high)
		else $error("blocked exception did not go to reset vector");
	chk_ctrl_take: assert property (bnd && quiet && !blk && i_encoded_level_inputs == 4'h0
		&& i_ctrl_req && i_ctrl_level > mask |=> o_ctrl_accept && o_branch)
		else $error("controller request not taken");
	chk_accept_cause: assert property (o_ctrl_accept |-> $past(i_ctrl_req && i_boundary))
		else $error("acceptance without request");
	chk_reset_idle: assert property (!o_reset_output_pin
		&& o_cpu_state_pin_low == o_cpu_state_pin_high)
		else $error("reset pin or state pins wrong");
	chk_return_jump: assert property (bnd && i_return_from_exception && !i_exc_req
		|=> o_branch)
		else $error("return did not branch");
endmodule : cpu_interrupt_acceptance_props

bind cpu_interrupt_acceptance cpu_interrupt_acceptance_props cpu_interrupt_acceptance_props_i (.*);

// *** verification/int_ctrl_model.sv ***
// Interrupt controller stand-in presenting one prioritized request.
// Assumes the bench posts requests and the CPU acknowledges them.
`timescale 1ns/100ps

module int_ctrl_model
	import cpu_interrupt_acceptance_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Bench side
	input  wire logic              i_post,
	input  wire logic [MASK_W-1:0] i_post_level,
	input  wire logic [CODE_W-1:0] i_post_code,
	// CPU side
	input  wire logic              i_ctrl_accept,
	output logic                   o_ctrl_req,
	output logic      [MASK_W-1:0] o_ctrl_level,
	output logic      [CODE_W-1:0] o_ctrl_code
);
	// Hold request until acknowledged; idle lines toggle so stale values never look valid
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ctrl_req <= 1'b0;
			o_ctrl_level <= '0;
			o_ctrl_code <= '0;
		end
		else if (i_post)
		begin
			o_ctrl_req <= 1'b1;
			o_ctrl_level <= i_post_level;
			o_ctrl_code <= i_post_code;
		end
		else if (i_ctrl_accept)
			o_ctrl_req <= 1'b0;
		else if (!o_ctrl_req)
		begin
			o_ctrl_level <= ~o_ctrl_level;
			o_ctrl_code <= ~o_ctrl_code;
		end
	end
endmodule : int_ctrl_model

// *** verification/cpu_interrupt_acceptance_tb.sv ***
// Self-checking bench for interrupt acceptance and exception return.
// Assumes APB answers are awaited, never counted; one 100 MHz clock.
`timescale 1ns/100ps

module cpu_interrupt_acceptance_tb;
	import cpu_interrupt_acceptance_pkg::*;

	// ==========================================================
	// Signals
	// ==========================================================
	logic              i_clock = 0, i_rst = 1, i_enable = 1;
	logic              i_psel = 0, i_penable = 0, i_pwrite = 0, o_pready, o_pslverr;
	logic [7:0]        i_paddr = 0;
	logic [31:0]       i_pwdata = 0, o_prdata, rd, o_branch_addr, o_status_word;
	logic              i_boundary = 0, i_sleep = 0, i_in_delay_slot = 0;
	logic              i_cond_branch = 0, i_cond_failed = 0, i_return_from_exception = 0;
	logic              i_exc_req = 0, i_exc_reexec = 0, i_exc_user_break = 0, err;
	logic [31:0]       i_cur_pc = 32'h100, i_next_pc = 32'h102, i_branch_pc = 32'hfe;
	logic [31:0]       i_branch_target = 32'h400, i_delay_slot_pc = 32'h104;
	logic [CODE_W-1:0] i_exc_code = 12'h180, i_ctrl_code, post_code = 0;
	logic [MASK_W-1:0] i_encoded_level_inputs = 0, i_ctrl_level, post_level = 0;
	logic              i_nmi = 0, i_debug_port_cmd = 0, i_ctrl_req, o_ctrl_accept, post = 0;
	logic              o_branch, o_reset_output_pin, o_cpu_state_pin_low, o_cpu_state_pin_high;
	logic [3:0]        mode [5] = '{4'h8, 4'he, 4'hf, 4'h2, 4'h3};
	logic [31:0]       pcs [5] = '{32'h100, 32'hfe, 32'h104, 32'h400, 32'h104};
	int                n_fail = 0, samples_checked = 0;

	cpu_interrupt_acceptance cpu_interrupt_acceptance_i (.*);
	int_ctrl_model int_ctrl_model_i (.i_clock(i_clock), .i_rst(i_rst), .i_post(post),
		.i_post_level(post_level), .i_post_code(post_code), .i_ctrl_accept(o_ctrl_accept),
		.o_ctrl_req(i_ctrl_req), .o_ctrl_level(i_ctrl_level), .o_ctrl_code(i_ctrl_code));

	// Free-running clock
	always #5 i_clock = ~i_clock;

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits on pready with a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge i_clock);
			k++;
		end
		while (o_pready !== 1'b1 && k < 20);
		// Judge by pready itself so an answer on the last try still counts
		if (o_pready !== 1'b1)
		begin
			n_fail++;
			stop_test();
		end
		else
		begin
			rd = o_prdata;
			err = o_pslverr;
			i_psel <= 1'b0;
			i_penable <= 1'b0;
		end
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdchk

	task automatic sr(input logic [31:0] v);
		apb(1'b1, ADDR_STATUS_WORD, v);
	endtask : sr

	// Boundary pulse; event inputs set at this edge are dropped after it
	task automatic step(input logic br, input logic [31:0] addr);
		i_boundary <= 1'b1;
		@(posedge i_clock);
		{i_boundary, i_exc_req, i_exc_reexec, i_exc_user_break, i_in_delay_slot} <= '0;
		{i_cond_branch, i_cond_failed, i_return_from_exception, i_sleep, i_nmi} <= '0;
		{i_debug_port_cmd, i_encoded_level_inputs} <= '0;
		#1;
		check(o_branch, br);
		if (br)
			check(o_branch_addr, addr);
	endtask : step

	// Watchdog on the whole run
	initial
	begin
		repeat (30000) @(posedge i_clock);
		n_fail++;
		stop_test();
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		repeat (6) @(posedge i_clock);
		check(o_branch_addr, RESET_VECTOR);
		check({o_status_word[30:28], o_status_word[7:4]}, 32'h7f);
		i_rst <= 1'b0;
		rdchk(ADDR_VECTOR_BASE, 32'h0);
		rdchk(ADDR_PC, RESET_VECTOR);
		rdchk(8'h40, 32'h0);
		check(err, 1'b1);
		apb(1'b1, ADDR_VECTOR_BASE, 32'h1000);
		// Edge on non-maskable pin while blocked, then unblock
		@(posedge i_clock);
		i_nmi <= 1'b1;
		i_encoded_level_inputs <= 4'h5;
		step(1'b0, 32'h0);
		sr(32'h0);
		// Level request competes with the held-off edge; the edge must win
		i_encoded_level_inputs <= 4'h5;
		step(1'b1, 32'h1600);
		check(o_status_word[30:28], 3'h7);
		rdchk(ADDR_INT_CODE, 32'h1c0);
		rdchk(ADDR_INT_CODE_2, 32'h1c0);
		rdchk(ADDR_SAVED_PC, 32'h102);
		rdchk(ADDR_SAVED_STATUS, 32'h0);
		// Frozen clock enable ignores a boundary
		sr(32'h0);
		i_enable <= 1'b0;
		i_encoded_level_inputs <= 4'h2;
		step(1'b0, 32'h0);
		// Restore enable on a rising edge, not mid-cycle
		@(posedge i_clock);
		i_enable <= 1'b1;
		// Every encoded level from 1 to 15, at and just above the mask
		for (int lv = 1; lv < 16; lv++)
		begin
			sr({24'h0, lv[3:0], 4'h0});
			i_encoded_level_inputs <= lv[3:0];
			step(1'b0, 32'h0);
			sr({24'h0, lv[3:0] - 4'h1, 4'h0});
			i_encoded_level_inputs <= lv[3:0];
			step(1'b1, 32'h1600);
			check(o_status_word, 32'h70000000 | ((lv - 1) << 4));
			rdchk(ADDR_INT_CODE, 32'h200 + lv * 32'h20);
			rdchk(ADDR_INT_CODE_2, 32'h200 + lv * 32'h20);
		end
		// Controller request at and above the mask
		sr(32'h60);
		post <= 1'b1;
		post_level <= 4'h6;
		post_code <= 12'h3a0;
		@(posedge i_clock);
		post <= 1'b0;
		step(1'b0, 32'h0);
		sr(32'h50);
		step(1'b1, 32'h1600);
		check(o_ctrl_accept, 1'b1);
		rdchk(ADDR_INT_CODE, 32'h3a0);
		// Debug command held pending across mask 15
		sr(32'hf0);
		i_debug_port_cmd <= 1'b1;
		step(1'b0, 32'h0);
		step(1'b0, 32'h0);
		sr(32'he0);
		step(1'b1, 32'h1600);
		rdchk(ADDR_INT_CODE_2, 32'h5e0);
		// Return restores PC and status
		// Block is still set from the debug entry while the copies reload
		apb(1'b1, ADDR_SAVED_PC, 32'h2468);
		apb(1'b1, ADDR_SAVED_STATUS, 32'h30);
		// Return boundary and the one after it carry no exception
		i_return_from_exception <= 1'b1;
		step(1'b1, 32'h2468);
		check(o_status_word, 32'h30);
		// Sleep lets a request through the block
		sr(32'h10000000);
		i_sleep <= 1'b1;
		i_encoded_level_inputs <= 4'h3;
		step(1'b1, 32'h1600);
		sr(32'h10000000);
		i_exc_req <= 1'b1;
		i_exc_user_break <= 1'b1;
		step(1'b0, 32'h0);
		sr(32'h10000000);
		// Illegal-instruction kind, never a translation fault after the load
		i_exc_req <= 1'b1;
		step(1'b1, RESET_VECTOR);
		check({o_cpu_state_pin_high, o_cpu_state_pin_low, o_reset_output_pin}, 3'h6);
		@(posedge i_clock);
		step(1'b0, 32'h0);
		check({o_cpu_state_pin_high, o_cpu_state_pin_low}, 2'h0);
		// Saved PC choice for re-executing and conditional-branch exception kinds
		for (int c = 0; c < 5; c++)
		begin
			sr(32'h0);
			i_exc_req <= 1'b1;
			{i_exc_reexec, i_in_delay_slot, i_cond_branch, i_cond_failed} <= mode[c];
			step(1'b1, 32'h1100);
			rdchk(ADDR_SAVED_PC, pcs[c]);
		end
		rdchk(ADDR_EXC_CODE, 32'h180);
		stop_test();
	end
endmodule : cpu_interrupt_acceptance_tb
